// file: src/rdl_regs.svh
// Timing and reset constants of the receive rail and data-link port.
// Assumes inclusion by bare name from files under src/.
`ifndef RDL_REGS_SVH
`define RDL_REGS_SVH
`define RDL_FRAME_BITS 193
`define RDL_SLOT_OFFSET 1
`define RDL_BITS_PER_SLOT 8
`define RDL_SYNC_WIDTH 5
`define RDL_RST_LEVEL 1'h0
`define RDL_RST_POS 8'h00
`endif

// file: src/rdl_pkg.sv
// Types of the receive rail and data-link port.
// Assumes nothing beyond a SystemVerilog compiler.
package rdl_pkg;
   typedef enum logic [1:0] {
      RDL_NONE,
      RDL_NEG,
      RDL_POS,
      RDL_BAD
   } rdl_pulse_t;
endpackage : rdl_pkg

// file: src/rdl_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static relative to core_clk.
`timescale 1ns/10ps
module rdl_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // First stage is read only by the second
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : rdl_sync

// file: src/rdl_port.sv
// Receive rail input decode, receive clock and rail outputs, data-link port.
// Assumes pins are asynchronous and the config/line inputs are core_clk.
//
// Summary of operation
// R1 - The line clock samples the rail inputs only in dual-rail mode.
// R2 - Rail inputs are captured on the falling edge of the line clock.
// R3 - Rail pairs decode as 00 none, 01 negative, 10 positive, 11 invalid.
// R4 - A unipolar source drives one rail and holds the other low.
// R5 - The receive clock output follows the recovered or dejittered clock.
// R6 - Rail outputs change on the rising receive clock edge, one per polarity.
// R7 - Link data is NRZ line data that changes on the falling clock edge.
// R8 - Every received bit appears on the link data output.
// R9 - The gapped clock pulses high in the clock low phase of selected bits.
// R10 - The link controller takes only bits marked by the gapped clock.
// R11 - Selected bits come from config inputs referenced to frame position.
`timescale 1ns/10ps
`include "rdl_regs.svh"
module rdl_port #(
   parameter int FRAME_BITS = `RDL_FRAME_BITS,
   parameter int SLOT_OFFSET = `RDL_SLOT_OFFSET
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic rx_line_clock_in,
   input wire logic rx_pos_rail_in,
   input wire logic rx_neg_rail_in,
   input wire logic recovered_line_clock,
   input wire logic dejittered_clock,
   input wire logic dual_rail_input_select,
   input wire logic jitter_clock_select_control,
   input wire logic line_bit_valid,
   input wire logic line_pos_pulse,
   input wire logic line_neg_pulse,
   input wire logic frame_start,
   input wire logic [4:0] link_slot,
   input wire logic [7:0] link_bit_mask,
   output logic rx_clock_out,
   output logic rx_pos_rail_out,
   output logic rx_neg_rail_out,
   output logic rx_link_data_out,
   output logic rx_link_gapped_clock,
   output logic rail_code_invalid
);
   import rdl_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [4:0] pin_s;
   logic line_clk_prev;
   logic line_clk_s, pos_s, neg_s, rec_s, dej_s;

   rdl_sync #(.WIDTH(`RDL_SYNC_WIDTH)) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in({rx_line_clock_in, rx_pos_rail_in, rx_neg_rail_in,
                 recovered_line_clock, dejittered_clock}),
      .sync_out(pin_s)
   );
   assign {line_clk_s, pos_s, neg_s, rec_s, dej_s} = pin_s;

   function automatic rdl_pulse_t rdl_decode(input logic p, input logic n);
      rdl_decode = rdl_pulse_t'({p, n} == 2'h3 ? RDL_BAD :
                   p ? RDL_POS : n ? RDL_NEG : RDL_NONE); // R3
   endfunction : rdl_decode

   // ==========================================================
   // Rail capture
   logic capture;
   rdl_pulse_t pend;

   always_ff @(posedge core_clk) begin
      if (reset)
         line_clk_prev <= `RDL_RST_LEVEL;
      else
         line_clk_prev <= line_clk_s;
   end

   // Line clock ignored unless dual-rail mode
   assign capture = dual_rail_input_select
                    & line_clk_prev & ~line_clk_s; // R1 R2

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pend <= RDL_NONE;
         rail_code_invalid <= `RDL_RST_LEVEL;
      end else begin
         rail_code_invalid <= `RDL_RST_LEVEL;
         if (capture) begin
            pend <= rdl_decode(pos_s, neg_s); // R2 R3
            rail_code_invalid <= pos_s & neg_s; // R3
         end else if (!dual_rail_input_select && line_bit_valid) begin
            pend <= rdl_decode(line_pos_pulse, line_neg_pulse);
            rail_code_invalid <= line_pos_pulse & line_neg_pulse;
         end
      end
   end

   // ==========================================================
   // Receive clock and rail outputs
   logic clk_sel, clk_rise, clk_fall;

   assign clk_sel = jitter_clock_select_control ? dej_s : rec_s; // R5
   assign clk_rise = clk_sel & ~rx_clock_out;
   assign clk_fall = ~clk_sel & rx_clock_out;

   always_ff @(posedge core_clk) begin
      if (reset)
         rx_clock_out <= `RDL_RST_LEVEL;
      else
         rx_clock_out <= clk_sel; // R5
   end

   // Invalid pairs leave both rails low
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_pos_rail_out <= `RDL_RST_LEVEL;
         rx_neg_rail_out <= `RDL_RST_LEVEL;
      end else if (clk_rise) begin
         rx_pos_rail_out <= (pend == RDL_POS); // R6
         rx_neg_rail_out <= (pend == RDL_NEG); // R6
      end
   end

   // ==========================================================
   // Frame position and slot selection
   logic [7:0] bit_pos;
   logic [7:0] rel_pos;
   logic slot_hit;

   always_ff @(posedge core_clk) begin
      if (reset)
         bit_pos <= `RDL_RST_POS;
      else if (clk_rise) begin
         if (frame_start || bit_pos == 8'(FRAME_BITS - 1))
            bit_pos <= `RDL_RST_POS; // R11
         else
            bit_pos <= bit_pos + 8'h01;
      end
   end

   assign rel_pos = bit_pos - 8'(SLOT_OFFSET);
   assign slot_hit = (bit_pos >= 8'(SLOT_OFFSET))
                     && (rel_pos[7:3] == link_slot)
                     && link_bit_mask[rel_pos[2:0]]; // R11

   // ==========================================================
   // Data-link output and gapped clock
   always_ff @(posedge core_clk) begin
      if (reset)
         rx_link_data_out <= `RDL_RST_LEVEL;
      else if (clk_fall)
         rx_link_data_out <= rx_pos_rail_out | rx_neg_rail_out; // R7 R8
   end

   // High only while the receive clock is low
   always_ff @(posedge core_clk) begin
      if (reset)
         rx_link_gapped_clock <= `RDL_RST_LEVEL;
      else if (clk_fall)
         rx_link_gapped_clock <= slot_hit; // R9 R11
      else if (clk_rise)
         rx_link_gapped_clock <= `RDL_RST_LEVEL; // R9
   end

   // ==========================================================
   // Checks
   a_line_clk_ignored: assert property (@(posedge core_clk) disable iff (reset)
      !dual_rail_input_select && !line_bit_valid |=> $stable(pend)) // R1
      else $error("line clock used outside dual-rail mode");

   a_capture_on_fall: assert property (@(posedge core_clk) disable iff (reset)
      capture |-> $fell(line_clk_s)) // R2
      else $error("rail capture not on line clock fall");

   a_decode_value: assert property (@(posedge core_clk) disable iff (reset)
      capture |=> pend == ($past(pos_s) ? ($past(neg_s) ? RDL_BAD : RDL_POS)
                           : ($past(neg_s) ? RDL_NEG : RDL_NONE))) // R3
      else $error("rail pair decoded wrongly");

   a_decode_invalid: assert property (@(posedge core_clk) disable iff (reset)
      capture && pos_s && neg_s |=> rail_code_invalid) // R3
      else $error("invalid rail pair not flagged");

   a_clock_follow: assert property (@(posedge core_clk) disable iff (reset)
      ##1 rx_clock_out == $past(jitter_clock_select_control ?
                                dej_s : rec_s)) // R5
      else $error("receive clock not from selected source");

   a_rails_on_rise: assert property (@(posedge core_clk) disable iff (reset)
      $changed(rx_pos_rail_out) || $changed(rx_neg_rail_out)
      |-> $rose(rx_clock_out)) // R6
      else $error("rail output changed off rising clock");

   a_rail_polarity: assert property (@(posedge core_clk) disable iff (reset)
      $rose(rx_clock_out) |-> rx_pos_rail_out == ($past(pend) == RDL_POS)
      && rx_neg_rail_out == ($past(pend) == RDL_NEG)) // R6
      else $error("rail output polarity wrong");

   a_link_on_fall: assert property (@(posedge core_clk) disable iff (reset)
      $changed(rx_link_data_out) |-> $fell(rx_clock_out)) // R7
      else $error("link data changed off falling clock");

   a_link_all_bits: assert property (@(posedge core_clk) disable iff (reset)
      $fell(rx_clock_out) |-> rx_link_data_out ==
      ($past(rx_pos_rail_out) | $past(rx_neg_rail_out))) // R8
      else $error("link data lost a received bit");

   a_gap_low_phase: assert property (@(posedge core_clk) disable iff (reset)
      rx_link_gapped_clock |-> !rx_clock_out) // R9
      else $error("gapped clock high in clock high phase");

   a_gap_selected: assert property (@(posedge core_clk) disable iff (reset)
      $fell(rx_clock_out) |-> rx_link_gapped_clock == $past(slot_hit)) // R11
      else $error("gapped clock does not follow slot selection");

   a_gap_on_fall: assert property (@(posedge core_clk) disable iff (reset)
      $rose(rx_link_gapped_clock) |-> $fell(rx_clock_out)) // R9
      else $error("gapped clock rose off falling clock");

   a_rails_exclusive: assert property (@(posedge core_clk) disable iff (reset)
      !(rx_pos_rail_out && rx_neg_rail_out)) // R3
      else $error("both rail outputs high");

   a_frame_restart: assert property (@(posedge core_clk) disable iff (reset)
      $rose(rx_clock_out) && $past(frame_start) |-> bit_pos == 8'h00) // R11
      else $error("frame start did not restart bit position");
endmodule : rdl_port

// file: dv/rdl_liu_model.sv
// External line interface model driving the dual-rail receive pins.
// Assumes the bench supplies the rail pair to send next.
`timescale 1ns/10ps
module rdl_liu_model (
   input wire logic [1:0] pair,
   output logic clk_out,
   output logic pos,
   output logic neg
);
   // ==========
   // Line clock
   initial clk_out = 1'h0;
   initial {pos, neg} = 2'h0;
   // Free running, unrelated in phase to the core clock
   always #41 clk_out = ~clk_out;
   // Rails move on the rise so they sit still at the fall
   always @(posedge clk_out) begin
      {pos, neg} <= pair;
   end
endmodule : rdl_liu_model

// file: dv/rx_dual_rail_data_link_port_tb.sv
// Self-checking bench for the receive rail and data-link port.
// Assumes rdl_port under src/ and the line interface model in dv/.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rx_dual_rail_data_link_port_tb;
   localparam int FB = 17;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic rec = 1'h0, dej = 1'h0, sel = 1'h1, jsel = 1'h0, bv = 1'h0;
   logic ipo = 1'h0, ine = 1'h0, pck = 1'h0, pg = 1'h0;
   logic [4:0] slot = 5'h00;
   logic [7:0] mask = 8'h00;
   logic [1:0] pair = 2'h0;
   logic lck, lp, ln, ck, po, no, dl, gk, inv;
   int bad_count = 0, tests_run = 0, seed = 6, cyc = 0, rises = 0;
   int gaps = 0, invs = 0, m, r0, g0;
   int pos_m = 0;
   localparam int SO = 1;
   logic fs = 1'h0, pfs = 1'h0;
   logic [12:0] pm = 13'h0000;
   logic lq[$];
   // Bench view of the selected bit positions
   function automatic logic slot_sel(input int p, input logic [12:0] c);
      int r;
      r = p - SO;
      if (r < 0) return 1'h0;
      return (r / 8 == c[12:8]) && c[r % 8];
   endfunction : slot_sel
   // ===================
   // Clocks and monitors
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) rec <= ~rec;
      if (cyc % 5 == 4) dej <= ~dej;
      pck <= ck;
      pg <= gk;
      if (ck && !pck) rises <= rises + 1;
      if (gk && !pg) gaps <= gaps + 1;
      if (inv === 1'h1) invs <= invs + 1;
      if (!reset) `CHK("gap_in_low", 1'h0, gk & ck)
      pfs <= fs;
      pm <= {slot, mask};
      if (ck && !pck) begin
         pos_m <= (pfs || pos_m == FB - 1) ? 0 : pos_m + 1;
      end
      // Link controller keeps only bits marked by the gapped clock
      if (!reset && !ck && pck) begin
         `CHK("gap_slot", slot_sel(pos_m, pm), gk)
         if (gk) lq.push_back(dl);
      end
   end
   rdl_liu_model rdl_liu_model_i (.pair(pair), .clk_out(lck), .pos(lp),
      .neg(ln));
   rdl_port #(.FRAME_BITS(FB), .SLOT_OFFSET(SO)) rdl_port_i (
      .core_clk(core_clk),
      .reset(reset), .rx_line_clock_in(lck), .rx_pos_rail_in(lp),
      .rx_neg_rail_in(ln), .recovered_line_clock(rec),
      .dejittered_clock(dej), .dual_rail_input_select(sel),
      .jitter_clock_select_control(jsel), .line_bit_valid(bv),
      .line_pos_pulse(ipo), .line_neg_pulse(ine), .frame_start(fs),
      .link_slot(slot), .link_bit_mask(mask), .rx_clock_out(ck),
      .rx_pos_rail_out(po), .rx_neg_rail_out(no), .rx_link_data_out(dl),
      .rx_link_gapped_clock(gk), .rail_code_invalid(inv));
   // =====
   // Tasks
   task automatic wrap_up;
      $display("counts run %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   task automatic wait_ck(input logic v);
      int i;
      for (i = 0; i < 60; i++) begin
         @(posedge core_clk);
         #1;
         if (ck === v) return;
      end
      bad_count++;
      $display("MISMATCH wait_ck exp %0h got timeout", v);
      wrap_up();
   endtask : wait_ck
   // Internal path gets the swapped pair so the two sources differ
   task automatic rails(input logic [1:0] p, input logic s);
      logic [1:0] q;
      @(posedge core_clk);
      q = s ? p : {p[0], p[1]};
      pair <= p;
      sel <= s;
      bv <= !s;
      {ine, ipo} <= p;
      // One internal bit only, so a stray line capture would show
      @(posedge core_clk);
      bv <= 1'h0;
      repeat (39) @(posedge core_clk);
      wait_ck(1'h1);
      wait_ck(1'h0);
      `CHK("pos_rail", q == 2'h2, po)
      `CHK("neg_rail", q == 2'h1, no)
      `CHK("link_data", q == 2'h1 || q == 2'h2, dl)
      $display("rails %0h select %0h done", p, s);
   endtask : rails
   // ====
   // Main
   initial begin
      repeat (6) @(posedge core_clk);
      `CHK("reset_out", 5'h00, {ck, po, no, dl, gk})
      reset <= 1'h0;
      for (m = 0; m < 8; m++) rails(m[1:0], !m[2]);
      `CHK("invalid", 1'h1, invs > 0)
      for (m = 0; m < 2; m++) begin
         @(posedge core_clk);
         jsel <= m[0];
         repeat (40) @(posedge core_clk);
         r0 = rises;
         repeat (400) @(posedge core_clk);
         `CHK("clk_rate", 1'h1, (rises - r0 - 50 + m * 10) inside {[-1:1]})
      end
      $display("clock select done");
      for (m = 0; m < 4; m++) begin
         @(posedge core_clk);
         r0 = $random(seed);
         slot <= {4'h0, r0[8]};
         mask <= r0[7:0];
         {ine, ipo} <= r0[10:9];
         bv <= 1'h1;
         fs <= 1'h1;
         @(posedge core_clk);
         bv <= 1'h0;
         wait_ck(1'h0);
         wait_ck(1'h1);
         @(posedge core_clk);
         fs <= 1'h0;
         repeat (20) @(posedge core_clk);
         wait_ck(1'h1);
         g0 = gaps;
         lq.delete();
         repeat (2 * FB) begin
            wait_ck(1'h0);
            wait_ck(1'h1);
         end
         `CHK("gap_count", 2 * $countones(r0[7:0]), gaps - g0)
         `CHK("link_bits", 2 * $countones(r0[7:0]), lq.size())
         foreach (lq[i]) `CHK("link_data", r0[9] ^ r0[10], lq[i])
      end
      $display("gapped clock done");
      wrap_up();
   end
endmodule : rx_dual_rail_data_link_port_tb
